// file: lcp_pkg.sv
// Package: register map, field layout, timing constants and carrier types of the LCD line timing block
package lcp_pkg;
  // ---------------------------------------------------------------------------
  // Register indices (byte address = 4 * index)
  // ---------------------------------------------------------------------------
  localparam logic [7:0] LINE_PERIOD_IDX = 8'hc6;
  localparam logic [7:0] LATCH_RISE_IDX = 8'hc8;
  localparam logic [7:0] LATCH_FALL_IDX = 8'hc9;
  localparam logic [7:0] PANEL_WIDTH_IDX = 8'hca;
  localparam logic [7:0] PANEL_HEIGHT_IDX = 8'hcb;
  localparam logic [7:0] PANEL_MODE_IDX = 8'hcc;
  localparam logic [7:0] PANEL_CTRL_IDX = 8'hcd;
  localparam logic [7:0] PANEL_STATUS_IDX = 8'hce;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [7:0] LINE_PERIOD_RST = 8'h1f;
  localparam logic [7:0] LATCH_RISE_RST = 8'h00;
  localparam logic [7:0] LATCH_FALL_RST = 8'h00;
  localparam logic [7:0] PANEL_WIDTH_RST = 8'h00;
  localparam logic [7:0] PANEL_HEIGHT_RST = 8'h00;
  localparam logic [7:0] PANEL_MODE_RST = 8'h00;
  localparam logic [7:0] PANEL_CTRL_RST = 8'h00;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int DELAY_FIELD_MSB = 4;
  localparam int LATE_FALL_BIT = 5;
  localparam int PULSE_TYPE_LSB = 6;
  localparam int LINE_DOUBLING_BIT = 5;
  localparam int GRAPHICS_RES_BIT = 6;
  localparam int REVERSE_VIDEO_BIT = 0;
  localparam int BLANK_BIT = 1;
  localparam int CENTER_BIT = 2;
  localparam int SEQ_DELAY_LSB = 3;
  localparam int DOWN_SEQ_EN_BIT = 5;
  localparam int UP_SEQ_EN_BIT = 6;
  localparam int PANEL_ON_BIT = 0;
  localparam logic [7:0] MODE_WRITE_MASK = 8'h7f;
  localparam logic [7:0] RISE_WRITE_MASK = 8'h7f;

  // ---------------------------------------------------------------------------
  // Line geometry and timing
  // ---------------------------------------------------------------------------
  localparam logic [8:0] TAIL_CONTINUOUS = 9'h002;
  localparam logic [8:0] TAIL_SUPPRESSED = 9'h004;
  localparam int CLK_MHZ = 50;
  localparam int SEQ_BASE_US_X10 = 75000;
  localparam int SEQ_BASE_CYCLES = SEQ_BASE_US_X10 * CLK_MHZ / 10;

  typedef enum logic [2:0] {
    PWR_OFF = 3'b000,
    PWR_UP1 = 3'b001,
    PWR_UP2 = 3'b011,
    PWR_ON = 3'b010,
    PWR_DN1 = 3'b110,
    PWR_DN2 = 3'b111
  } lcp_pwr_state_t;

  typedef struct packed {
    logic frame_start;
    logic line_latch_pulse;
    logic panel_shift_clock;
  } lcp_panel_t;

  typedef struct packed {
    logic bias_enable;
    logic signals_enable;
    logic logic_power_enable;
  } lcp_power_t;
endpackage : lcp_pkg

// file: lcp_line_timing.sv
// Design: LCD line latch pulse timing, panel geometry, power sequencing and APB register file
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
module lcp_line_timing
  import lcp_pkg::*;
#(
  parameter int SEQ_STEP_CYCLES = SEQ_BASE_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pixel_clock_in,
  output lcp_panel_t panel,
  output lcp_power_t power,
  output logic [8:0] image_row,
  output logic reverse_video
);
  // ---------------------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------------------
  logic [7:0] line_period_reg;
  logic [7:0] latch_rise_timing_reg;
  logic [7:0] latch_fall_timing_reg;
  logic [7:0] panel_width_reg;
  logic [7:0] panel_height_reg;
  logic [7:0] panel_mode_reg;
  logic [7:0] panel_ctrl_reg;
  logic [31:0] prdata_reg;
  logic [8:0] line_cnt_reg;
  lcp_pwr_state_t pwr_state_reg;

  wire [7:0] reg_index = paddr[9:2];
  wire addr_high_zero = (paddr[11:10] == 2'b00);
  wire sel_period = addr_high_zero && (reg_index == LINE_PERIOD_IDX);
  wire sel_rise = addr_high_zero && (reg_index == LATCH_RISE_IDX);
  wire sel_fall = addr_high_zero && (reg_index == LATCH_FALL_IDX);
  wire sel_width = addr_high_zero && (reg_index == PANEL_WIDTH_IDX);
  wire sel_height = addr_high_zero && (reg_index == PANEL_HEIGHT_IDX);
  wire sel_mode = addr_high_zero && (reg_index == PANEL_MODE_IDX);
  wire sel_ctrl = addr_high_zero && (reg_index == PANEL_CTRL_IDX);
  wire sel_status = addr_high_zero && (reg_index == PANEL_STATUS_IDX);
  wire addr_hit = sel_period | sel_rise | sel_fall | sel_width | sel_height | sel_mode | sel_ctrl | sel_status;
  wire access_phase = psel && penable;
  wire wr_en = access_phase && pwrite && addr_hit;
  wire setup_phase = psel && !penable;

  // Reads are captured in the setup cycle so prdata comes from a flop; the slave never stalls
  assign pready = 1'b1;
  assign pslverr = access_phase && !addr_hit;
  assign prdata = prdata_reg;

  wire pwr_stable_on = (pwr_state_reg == PWR_ON);
  wire [31:0] status_word = {19'h00000, pwr_stable_on, 3'h0, line_cnt_reg};
  wire [31:0] read_mux =
    sel_period ? {24'h000000, line_period_reg} :
    sel_rise ? {24'h000000, latch_rise_timing_reg} :
    sel_fall ? {24'h000000, latch_fall_timing_reg} :
    sel_width ? {24'h000000, panel_width_reg} :
    sel_height ? {24'h000000, panel_height_reg} :
    sel_mode ? {24'h000000, panel_mode_reg} :
    sel_ctrl ? {24'h000000, panel_ctrl_reg} :
    sel_status ? status_word : 32'h00000000;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      line_period_reg <= LINE_PERIOD_RST;
      latch_rise_timing_reg <= LATCH_RISE_RST;
      latch_fall_timing_reg <= LATCH_FALL_RST;
    end else begin
      if (wr_en && sel_period) line_period_reg <= {3'h0, pwdata[DELAY_FIELD_MSB:0]};
      if (wr_en && sel_rise) latch_rise_timing_reg <= pwdata[7:0] & RISE_WRITE_MASK;
      if (wr_en && sel_fall) latch_fall_timing_reg <= pwdata[7:0];
    end
  end

  // Panel geometry, mode and control
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      panel_width_reg <= PANEL_WIDTH_RST;
      panel_height_reg <= PANEL_HEIGHT_RST;
      panel_mode_reg <= PANEL_MODE_RST;
      panel_ctrl_reg <= PANEL_CTRL_RST;
    end else begin
      if (wr_en && sel_width) panel_width_reg <= pwdata[7:0];
      if (wr_en && sel_height) panel_height_reg <= pwdata[7:0];
      if (wr_en && sel_mode) panel_mode_reg <= pwdata[7:0] & MODE_WRITE_MASK;
      if (wr_en && sel_ctrl) panel_ctrl_reg <= {7'h00, pwdata[PANEL_ON_BIT]};
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) prdata_reg <= 32'h00000000;
    else if (setup_phase) prdata_reg <= read_mux;
  end

  // ---------------------------------------------------------------------------
  // Field decode
  // ---------------------------------------------------------------------------
  wire [4:0] line_period_select = line_period_reg[DELAY_FIELD_MSB:0];
  wire [4:0] rise_delay_select = latch_rise_timing_reg[DELAY_FIELD_MSB:0];
  wire [4:0] fall_delay_select = latch_fall_timing_reg[DELAY_FIELD_MSB:0];
  wire late_fall_mode = latch_fall_timing_reg[LATE_FALL_BIT];
  wire [1:0] latch_pulse_type = latch_fall_timing_reg[PULSE_TYPE_LSB +: 2];
  wire line_doubling = latch_rise_timing_reg[LINE_DOUBLING_BIT];
  wire [7:0] panel_width_field = panel_width_reg;
  wire [7:0] panel_height_field = panel_height_reg;
  wire [1:0] power_sequence_delay = panel_mode_reg[SEQ_DELAY_LSB +: 2];
  wire power_up_sequence_enable = panel_mode_reg[UP_SEQ_EN_BIT];
  wire power_down_sequence_enable = panel_mode_reg[DOWN_SEQ_EN_BIT];
  wire panel_on_request = panel_ctrl_reg[PANEL_ON_BIT];

  // ---------------------------------------------------------------------------
  // Pixel clock synchroniser and edge detect
  // ---------------------------------------------------------------------------
  logic pclk_meta_reg;
  logic pclk_sync_reg;
  logic pclk_prev_reg;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pclk_meta_reg <= 1'b0;
      pclk_sync_reg <= 1'b0;
      pclk_prev_reg <= 1'b0;
    end else begin
      pclk_meta_reg <= pixel_clock_in;
      pclk_sync_reg <= pclk_meta_reg;
      pclk_prev_reg <= pclk_sync_reg;
    end
  end
  wire pix_tick = pclk_sync_reg && !pclk_prev_reg;

  // ---------------------------------------------------------------------------
  // Line sequencer: data shift periods, then the tail periods
  // ---------------------------------------------------------------------------
  // A line carries panel_width_field+1 data shift periods before the tail; the shift period is
  // line_period_select+1 pixel clocks, so the fall delay must stay below that field.
  logic [4:0] pix_cnt_reg;
  logic [8:0] shift_cnt_reg;
  logic shift_clock_reg;
  logic latch_reg;
  logic frame_start_reg;

  wire suppress_type = (latch_pulse_type != 2'b00);
  wire [8:0] data_periods = {1'b0, panel_width_field} + 9'h001;
  wire [8:0] tail_len = suppress_type ? TAIL_SUPPRESSED : TAIL_CONTINUOUS;
  wire [8:0] line_last = data_periods + tail_len - 9'h001;
  wire [8:0] type_extra = (latch_pulse_type == 2'b11) ? 9'h002 :
                          (latch_pulse_type == 2'b10) ? 9'h001 : 9'h000;
  wire [8:0] rise_period = data_periods + type_extra;
  // The fall is placed relative to the rise period, so the width never depends on the type
  wire [8:0] fall_period = rise_period + {8'h00, late_fall_mode};
  wire [5:0] rise_offset = {1'b0, rise_delay_select} + 6'h01;
  wire [5:0] fall_offset = {1'b0, fall_delay_select} + 6'h01;

  wire period_end = (pix_cnt_reg == line_period_select);
  wire line_end = period_end && (shift_cnt_reg >= line_last);
  // The pixel counter restarts on every shift rise, real or held back
  wire [4:0] pix_nxt = period_end ? 5'h00 : pix_cnt_reg + 5'h01;
  wire [8:0] shift_nxt = line_end ? 9'h000 : (period_end ? shift_cnt_reg + 9'h001 : shift_cnt_reg);
  wire in_suppress = suppress_type && (shift_nxt >= data_periods);
  wire shift_high_nxt = ({1'b0, pix_nxt} <= {2'b00, line_period_select[4:1]}) && !in_suppress;
  wire rise_hit = (shift_nxt == rise_period) && ({1'b0, pix_nxt} == rise_offset);
  wire fall_hit = (shift_nxt == fall_period) && ({1'b0, pix_nxt} == fall_offset);

  // ---------------------------------------------------------------------------
  // Frame and row tracking
  // ---------------------------------------------------------------------------
  wire [8:0] panel_lines = {panel_height_field, 1'b0} + 9'h002;
  wire frame_end = line_end && (line_cnt_reg >= panel_lines - 9'h001);
  wire [8:0] line_nxt = frame_end ? 9'h000 : (line_end ? line_cnt_reg + 9'h001 : line_cnt_reg);
  // Each image row is shown on two panel lines when doubling
  wire [8:0] row_nxt = line_doubling ? {1'b0, line_nxt[8:1]} : line_nxt;

  // Fall has priority when both hits land on one tick
  wire latch_next = fall_hit ? 1'b0 : (rise_hit ? 1'b1 : latch_reg);
  wire frame_start_next = (line_nxt == 9'h000) && (shift_nxt < data_periods);
  logic sig_en;

  // Position counters run while the panel is dark, so a re-enabled panel resumes mid-frame
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pix_cnt_reg <= 5'h00;
      shift_cnt_reg <= 9'h000;
      line_cnt_reg <= 9'h000;
      image_row <= 9'h000;
    end else if (pix_tick) begin
      pix_cnt_reg <= pix_nxt;
      shift_cnt_reg <= shift_nxt;
      line_cnt_reg <= line_nxt;
      image_row <= row_nxt;
    end
  end

  // Panel lines drop on the first clk with signals off instead of waiting for a pixel tick
  always_ff @(posedge clk) begin
    if (!reset_n || !sig_en) begin
      shift_clock_reg <= 1'b0;
      latch_reg <= 1'b0;
      frame_start_reg <= 1'b0;
    end else if (pix_tick) begin
      shift_clock_reg <= shift_high_nxt;
      latch_reg <= latch_next;
      frame_start_reg <= frame_start_next;
    end
  end

  assign panel.panel_shift_clock = shift_clock_reg;
  assign panel.line_latch_pulse = latch_reg;
  assign panel.frame_start = frame_start_reg;

  // ---------------------------------------------------------------------------
  // Panel power sequencing
  // ---------------------------------------------------------------------------
  // Step delay doubles per code: 00..11 give 1x, 2x, 4x, 8x the base step
  logic [23:0] seq_cnt_reg;
  lcp_pwr_state_t pwr_state_next;
  logic [2:0] pwr_out_reg;
  wire [23:0] seq_target = 24'(SEQ_STEP_CYCLES) << power_sequence_delay;
  wire seq_done = (seq_cnt_reg >= seq_target - 24'h000001);

  always_comb begin
    pwr_state_next = pwr_state_reg;
    case (pwr_state_reg)
      PWR_OFF: begin
        if (panel_on_request) pwr_state_next = power_up_sequence_enable ? PWR_UP1 : PWR_ON;
      end
      PWR_UP1: begin
        if (!panel_on_request) pwr_state_next = PWR_OFF;
        else if (seq_done) pwr_state_next = PWR_UP2;
      end
      PWR_UP2: begin
        if (!panel_on_request) pwr_state_next = PWR_DN1;
        else if (seq_done) pwr_state_next = PWR_ON;
      end
      PWR_ON: begin
        if (!panel_on_request) pwr_state_next = power_down_sequence_enable ? PWR_DN1 : PWR_OFF;
      end
      PWR_DN1: begin
        if (seq_done) pwr_state_next = PWR_DN2;
      end
      PWR_DN2: begin
        if (seq_done) pwr_state_next = PWR_OFF;
      end
      default: pwr_state_next = PWR_OFF;
    endcase
  end

  // Outputs per state: {bias, clocks and data, logic power}
  wire [2:0] pwr_out_next =
    (pwr_state_next == PWR_UP1) ? 3'h1 :
    (pwr_state_next == PWR_UP2) ? 3'h3 :
    (pwr_state_next == PWR_ON) ? 3'h7 :
    (pwr_state_next == PWR_DN1) ? 3'h3 :
    (pwr_state_next == PWR_DN2) ? 3'h1 : 3'h0;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pwr_state_reg <= PWR_OFF;
      seq_cnt_reg <= 24'h000000;
      pwr_out_reg <= 3'h0;
    end else begin
      pwr_state_reg <= pwr_state_next;
      seq_cnt_reg <= (pwr_state_next != pwr_state_reg) ? 24'h000000 : seq_cnt_reg + 24'h000001;
      pwr_out_reg <= pwr_out_next;
    end
  end

  assign sig_en = pwr_out_reg[1];
  assign power.logic_power_enable = pwr_out_reg[0];
  assign power.signals_enable = pwr_out_reg[1];
  assign power.bias_enable = pwr_out_reg[2];

  logic reverse_video_reg;
  always_ff @(posedge clk) begin
    if (!reset_n) reverse_video_reg <= 1'b0;
    else reverse_video_reg <= panel_mode_reg[REVERSE_VIDEO_BIT];
  end
  assign reverse_video = reverse_video_reg;
endmodule : lcp_line_timing

// file: lcp_line_timing_monitor.sv
// Checker: port-level properties of the LCD line timing block
`timescale 1ns/1ps
module lcp_line_timing_monitor
  import lcp_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic pixel_clock_in,
  input wire lcp_panel_t panel,
  input wire lcp_power_t power,
  input wire logic [8:0] image_row,
  input wire logic reverse_video
);
  logic [7:0] idx;
  logic mapped;
  logic access;
  assign idx = paddr[9:2];
  assign mapped = paddr[11:10] == 2'b00 && (idx == LINE_PERIOD_IDX || (idx >= LATCH_RISE_IDX && idx <= PANEL_STATUS_IDX));
  assign access = psel && penable;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_access;
    psel && penable;
  endsequence
  // Panel lines only move on pixel ticks while signals are on, eight clk apart, so any level lasts that long
  sequence s_dark;
    !power.signals_enable [*2];
  endsequence
  property p_zero_wait; s_access |-> pready; endproperty
  property p_err_unmapped; access && !mapped |-> pslverr; endproperty
  property p_err_mapped; access && mapped |-> !pslverr; endproperty
  property p_err_idle; !access |-> !pslverr; endproperty
  property p_narrow_read; access && !pwrite && mapped && idx != PANEL_STATUS_IDX |-> prdata[31:8] == 24'h000000; endproperty
  property p_power_order; power.bias_enable |-> power.signals_enable && power.logic_power_enable; endproperty
  property p_dark_panel; s_dark |-> panel == '0; endproperty
  property p_latch_hold; $rose(panel.line_latch_pulse) |-> (panel.line_latch_pulse || !power.signals_enable) [*8]; endproperty
  property p_shift_hold; $rose(panel.panel_shift_clock) |-> (panel.panel_shift_clock || !power.signals_enable) [*8]; endproperty
  property p_release; $rose(reset_n) |-> power == '0 && panel == '0 && image_row == 9'h000; endproperty
  a_zero_wait: assert property (p_zero_wait) else $error("access phase without ready");
  a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped access without error");
  a_err_mapped: assert property (p_err_mapped) else $error("mapped access flagged as error");
  a_err_idle: assert property (p_err_idle) else $error("error outside access phase");
  a_narrow_read: assert property (p_narrow_read) else $error("register read has upper bits set");
  a_power_order: assert property (p_power_order) else $error("power steps out of order");
  a_dark_panel: assert property (p_dark_panel) else $error("panel driven while signals off");
  a_latch_hold: assert property (p_latch_hold) else $error("latch pulse shorter than a pixel tick");
  a_shift_hold: assert property (p_shift_hold) else $error("shift clock shorter than a pixel tick");
  a_release: assert property (p_release) else $error("outputs not idle after reset");
endmodule : lcp_line_timing_monitor

bind lcp_line_timing lcp_line_timing_monitor u_mon (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pixel_clock_in(pixel_clock_in), .panel(panel), .power(power), .image_row(image_row), .reverse_video(reverse_video));

// file: lcp_panel_model.sv
// Panel model: makes the pixel clock and measures latch and shift timing in pixel ticks
`timescale 1ns/1ps
module lcp_panel_model
  import lcp_pkg::*;
(
  output logic pixel_clock_in,
  input wire lcp_panel_t panel,
  output logic [15:0] latch_width,
  output logic [15:0] line_ticks,
  output logic [15:0] shifts_per_line,
  output logic [15:0] rise_after_shift,
  output logic [15:0] lines_per_frame,
  output logic [15:0] line_count
);
  logic [15:0] tick, t_shift, t_latch, n_shift, n_line;
  lcp_panel_t last;
  // Panel clock runs free; the odd start keeps its edges off the clk edges
  initial begin
    {tick, t_shift, t_latch, n_shift, n_line, last} = '0;
    {latch_width, line_ticks, shifts_per_line, rise_after_shift, lines_per_frame, line_count} = '0;
    pixel_clock_in = 1'b0;
    #7;
    forever #80 pixel_clock_in = ~pixel_clock_in;
  end
  always @(posedge pixel_clock_in) begin
    tick <= tick + 16'h0001;
    last <= panel;
    if (panel.panel_shift_clock && !last.panel_shift_clock) begin
      t_shift <= tick;
      n_shift <= n_shift + 16'h0001;
    end
    // Suppressed tail periods show up as missing shift rises
    if (panel.line_latch_pulse && !last.line_latch_pulse) begin
      line_ticks <= tick - t_latch;
      t_latch <= tick;
      rise_after_shift <= tick - t_shift;
      shifts_per_line <= n_shift;
      n_shift <= 16'h0000;
      n_line <= n_line + 16'h0001;
      line_count <= line_count + 16'h0001;
    end
    if (!panel.line_latch_pulse && last.line_latch_pulse) begin
      latch_width <= tick - t_latch;
    end
    if (panel.frame_start && !last.frame_start) begin
      lines_per_frame <= n_line;
      n_line <= 16'h0000;
    end
  end
endmodule : lcp_panel_model

// file: testbench.sv
// Testbench: registers, latch timing, panel geometry and power sequencing
`timescale 1ns/1ps
module testbench;
  import lcp_pkg::*;
  localparam int STEP = 20;
  logic clk, reset_n, psel, penable, pwrite, pready, pslverr, pixel_clock_in, reverse_video, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  lcp_panel_t panel;
  lcp_power_t power;
  logic [8:0] image_row;
  logic [15:0] latch_width, line_ticks, shifts_per_line, rise_after_shift, lines_per_frame, line_count;
  int mismatches, checks_done;
  lcp_line_timing #(.SEQ_STEP_CYCLES(STEP)) u_dut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pixel_clock_in(pixel_clock_in), .panel(panel), .power(power), .image_row(image_row), .reverse_video(reverse_video));
  lcp_panel_model u_panel (.pixel_clock_in(pixel_clock_in), .panel(panel), .latch_width(latch_width),
    .line_ticks(line_ticks), .shifts_per_line(shifts_per_line), .rise_after_shift(rise_after_shift),
    .lines_per_frame(lines_per_frame), .line_count(line_count));
  always #10 clk = ~clk;
  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
    checks_done++;
    if (seen !== want) begin
      mismatches++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, want);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) mismatches++;
  endtask : apb
  task automatic wait_lines(input int k);
    int n;
    logic [15:0] start;
    n = 0;
    start = line_count;
    while (line_count - start < k && n < 20000) begin
      @(posedge clk);
      n++;
    end
    check({31'h0, n < 20000}, 32'h1, "line wait");
  endtask : wait_lines
  task automatic wait_power(input lcp_power_t want, output int n);
    n = 0;
    while (power !== want && n < 1000) begin
      @(posedge clk);
      n++;
    end
  endtask : wait_power
  task automatic give_verdict();
    $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict
  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_registers();
    logic [7:0] ids [8] = '{LINE_PERIOD_IDX, LATCH_RISE_IDX, LATCH_FALL_IDX, PANEL_WIDTH_IDX, PANEL_HEIGHT_IDX,
      PANEL_MODE_IDX, PANEL_CTRL_IDX, PANEL_STATUS_IDX};
    logic [7:0] rst [8] = '{LINE_PERIOD_RST, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, ids[i], 32'h0);
      check(rd, {24'h0, rst[i]}, "reset value");
    end
    apb(1'b1, 8'hc7, 32'hff);
    check({31'h0, err}, 32'h1, "unmapped write error");
    apb(1'b0, 8'hc7, 32'h0);
    check(rd, 32'h0, "unmapped read");
    apb(1'b1, PANEL_STATUS_IDX, 32'hff);
    check({31'h0, err}, 32'h0, "status write error");
    apb(1'b1, PANEL_WIDTH_IDX, 32'h9f);
    apb(1'b0, PANEL_WIDTH_IDX, 32'h0);
    check(rd, 32'h9f, "width field");
    apb(1'b1, PANEL_MODE_IDX, 32'hff);
    apb(1'b0, PANEL_MODE_IDX, 32'h0);
    check(rd, 32'h7f, "mode reserved bit");
    check({31'h0, reverse_video}, 32'h1, "reverse video");
    apb(1'b1, PANEL_MODE_IDX, 32'h0);
    apb(1'b1, PANEL_WIDTH_IDX, 32'h0);
  endtask : t_registers
  task automatic t_line(input logic late, input logic [1:0] typ, input int wid, input int ln, input int sh, input int rs);
    apb(1'b1, LATCH_FALL_IDX, {24'h0, typ, late, 5'd3});
    wait_lines(3);
    check({16'h0, latch_width}, wid, "latch width");
    check({16'h0, line_ticks}, ln, "line length");
    check({16'h0, shifts_per_line}, sh, "shift rises per line");
    check({16'h0, rise_after_shift}, rs, "latch rise delay");
  endtask : t_line
  task automatic t_power();
    int d0, d1, d2;
    apb(1'b1, PANEL_CTRL_IDX, 32'h0);
    repeat (2) @(posedge clk);
    check({29'h0, power}, 32'h0, "immediate power off");
    apb(1'b1, PANEL_MODE_IDX, 32'h68);
    apb(1'b1, PANEL_CTRL_IDX, 32'h1);
    wait_power(3'b001, d0);
    wait_power(3'b011, d1);
    wait_power(3'b111, d2);
    check({31'h0, d1 >= 2 * STEP && d1 <= 2 * STEP + 1}, 32'h1, "up step one");
    check({31'h0, d2 >= 2 * STEP && d2 <= 2 * STEP + 1}, 32'h1, "up step two");
    apb(1'b1, PANEL_CTRL_IDX, 32'h0);
    wait_power(3'b011, d0);
    wait_power(3'b001, d1);
    wait_power(3'b000, d2);
    check({31'h0, d1 >= 2 * STEP && d1 <= 2 * STEP + 1}, 32'h1, "down step one");
    check({31'h0, d2 >= 2 * STEP && d2 <= 2 * STEP + 1}, 32'h1, "down step two");
  endtask : t_power
  task automatic t_rows();
    for (int d = 0; d < 2; d++) begin
      apb(1'b1, LATCH_RISE_IDX, {26'h0, d[0], 5'h01});
      @(posedge panel.frame_start);
      for (int i = 0; i < 4; i++) begin
        @(posedge panel.line_latch_pulse);
        @(posedge clk);
        check({23'h0, image_row}, d ? i / 2 : i, "image row");
      end
    end
  endtask : t_rows
  // Line period 7 gives 8 ticks a shift period; rise 1, fall 3
  initial begin
    {clk, reset_n, psel, penable, pwrite, paddr, pwdata, mismatches, checks_done} = '0;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    t_registers();
    apb(1'b1, LINE_PERIOD_IDX, 32'h7);
    apb(1'b1, LATCH_RISE_IDX, 32'h1);
    apb(1'b1, PANEL_CTRL_IDX, 32'h1);
    wait_lines(4);
    check({16'h0, lines_per_frame}, 32'h2, "default height");
    for (int l = 0; l < 2; l++) begin
      for (int t = 0; t < 4; t++) begin
        t_line(l[0], t[1:0], l ? 10 : 2, t ? 40 : 24, t ? 1 : 3, 2 + 8 * t);
      end
    end
    apb(1'b1, PANEL_WIDTH_IDX, 32'h7);
    t_line(1'b0, 2'b00, 2, 80, 10, 2);
    apb(1'b1, PANEL_HEIGHT_IDX, 32'h1);
    wait_lines(10);
    check({16'h0, lines_per_frame}, 32'h4, "four line frame");
    t_rows();
    t_power();
    give_verdict();
  end
  initial begin
    #2000000;
    mismatches++;
    give_verdict();
  end
endmodule : testbench
